//--- design/ccr_cap_regs.sv
// Purpose: Read-only capability word and doorbell address decode.
// Assumes: Single clock, synchronous reset; host reads the word as two 32-bit halves.
// Notes:   Writes to the capability word are dropped.
//
// Behaviour
// - Bits 55:52 hold maximum page exponent
// - Bits 51:48 hold minimum page exponent
// - Bit 45 reports boot partition support
// - Bits 44:37 are command set mask
// - Mask nonzero; bit 37 is NVM set
// - Bit 36 reports subsystem reset support
// - Bits 35:32 give doorbell stride exponent
// - Stride zero means packed four-byte doorbells
// - Bits 31:24 ready timeout; ready meets it
// - Reserved bits read as zero
// - Doorbells at base plus stride slots
`include "ccr_consts.svh"
`default_nettype none
module ccr_cap_regs
	import ccr_pkg::*;
#(
	parameter logic [3:0] PAGE_MAX_EXP   = 4'h0,
	parameter logic [3:0] PAGE_MIN_EXP   = 4'h0,
	parameter logic       BOOT_SUPPORT   = 1'b0,
	parameter logic [7:0] CMD_SETS       = `CCR_NVM_CSS_MASK,
	parameter logic       SUBRST_SUPPORT = 1'b0,
	parameter logic [3:0] DBL_STRIDE     = 4'h0,
	parameter logic [7:0] READY_TIMEOUT  = 8'h01,
	parameter int unsigned READY_DELAY   = 16,
	parameter int unsigned NUM_QUEUES    = 16
) (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        rst,
	// Register access
	input  wire logic        reg_rd,
	input  wire logic        reg_wr,
	input  wire logic [15:0] reg_addr,
	input  wire logic [31:0] reg_wdata,
	output var  logic [31:0] reg_rdata_reg,
	output var  logic        reg_rvalid_reg,
	// Doorbell decode result
	output var  logic        dbl_hit_reg,
	output var  logic        dbl_completion_reg,
	output var  logic [11:0] dbl_queue_reg,
	// Enable and ready handshake
	input  wire logic        controller_enable,
	output var  logic        controller_ready,
	// Whole capability word for other logic
	output var  logic [63:0] controller_capabilities
);
	// Advertised ready bound in cycles at the nominal clock
	localparam longint unsigned TIMEOUT_CYCLES =
		64'(READY_TIMEOUT) * `CCR_TO_UNIT_MS * 1000 * `CCR_CLK_MHZ;

	// Decoder link and ready handshake state
	ccr_dbl_if      dbl ();
	ccr_rdy_state_t rdy_state_reg;
	logic [31:0]    rdy_cnt_reg;
	logic [31:0]    rdy_cnt_next;
	logic           en_reg;

	// Assemble the word; reserved ranges stay zero
	function automatic ccr_word_t build_cap();
		ccr_word_t w;
		w = 64'h0;
		w[`CCR_MAX_EXP_HI:`CCR_MAX_EXP_LO] = PAGE_MAX_EXP;
		w[`CCR_MIN_EXP_HI:`CCR_MIN_EXP_LO] = PAGE_MIN_EXP;
		w[`CCR_BOOT_BIT]                   = BOOT_SUPPORT;
		w[`CCR_CSS_HI:`CCR_CSS_LO]         = (CMD_SETS == 8'h0) ? `CCR_NVM_CSS_MASK : CMD_SETS;
		w[`CCR_SUBRST_BIT]                 = SUBRST_SUPPORT;
		w[`CCR_DOORBELL_STRIDE_HI:`CCR_DOORBELL_STRIDE_LO]     = DBL_STRIDE;
		w[`CCR_TO_HI:`CCR_TO_LO]           = READY_TIMEOUT;
		return w;
	endfunction

	// Constant word; no write path reaches it
	assign controller_capabilities = build_cap();

	// Doorbell lookup uses the advertised stride
	assign dbl.addr   = reg_addr;
	assign dbl.stride = controller_capabilities[`CCR_DOORBELL_STRIDE_HI:`CCR_DOORBELL_STRIDE_LO];
	ccr_dbl_decode #(
		.NUM_QUEUES (NUM_QUEUES)
	) u_dbl (
		.dbl (dbl)
	);

	// Address match on one half of the word; shared by both read arms
	function automatic logic cap_half_hit(input logic [15:0] addr, input logic upper);
		logic [15:0] want;
		want = upper ? 16'(`CCR_CAP_OFFSET + 12'h4) : 16'(`CCR_CAP_OFFSET);
		return addr == want;
	endfunction

	// Read strobe answered exactly one cycle later
	always_ff @(posedge clk) begin
		if (rst) begin
			reg_rvalid_reg <= 1'b0;
		end else begin
			reg_rvalid_reg <= reg_rd;
		end
	end

	// Read data: low or high half, else zero; holds until next read
	always_ff @(posedge clk) begin
		if (rst) begin
			reg_rdata_reg <= 32'h0;
		end else if (reg_rd) begin
			if (cap_half_hit(reg_addr, 1'b0)) begin
				reg_rdata_reg <= controller_capabilities[31:0];
			end else if (cap_half_hit(reg_addr, 1'b1)) begin
				reg_rdata_reg <= controller_capabilities[63:32];
			end else begin
				reg_rdata_reg <= 32'h0; // Unmapped here reads zero
			end
		end
	end

	// Hit is a one-cycle pulse per doorbell write
	always_ff @(posedge clk) begin
		if (rst) begin
			dbl_hit_reg <= 1'b0;
		end else begin
			dbl_hit_reg <= reg_wr && dbl.hit;
		end
	end

	// Slot fields only mean something while the hit pulse is high
	always_ff @(posedge clk) begin
		if (rst) begin
			dbl_completion_reg <= 1'b0;
			dbl_queue_reg      <= 12'h0;
		end else begin
			dbl_completion_reg <= dbl.is_completion;
			dbl_queue_reg      <= dbl.queue_id;
		end
	end

	// Countdown to the ready change; delay kept far under the timeout
	always_comb begin
		rdy_cnt_next = (rdy_cnt_reg == 32'h0) ? 32'h0 : rdy_cnt_reg - 32'h1;
	end

	// Enable sampled once; costs one cycle of ready latency
	always_ff @(posedge clk) begin
		if (rst) begin
			en_reg <= 1'b0;
		end else begin
			en_reg <= controller_enable;
		end
	end

	// Countdown loads on leaving a steady state, runs down to zero in the rising and falling states
	always_ff @(posedge clk) begin
		if (rst) begin
			rdy_cnt_reg <= 32'h0;
		end else begin
			case (rdy_state_reg)
				CCR_RDY_LOW: begin
					if (en_reg) begin
						rdy_cnt_reg <= 32'(READY_DELAY);
					end
				end
				CCR_RDY_HIGH: begin
					if (!en_reg) begin
						rdy_cnt_reg <= 32'(READY_DELAY);
					end
				end
				default: begin
					rdy_cnt_reg <= rdy_cnt_next;
				end
			endcase
		end
	end

	// Ready follows enable within READY_DELAY + 3 cycles
	always_ff @(posedge clk) begin
		if (rst) begin
			rdy_state_reg <= CCR_RDY_LOW;
		end else begin
			case (rdy_state_reg)
				CCR_RDY_LOW: begin
					if (en_reg) begin
						rdy_state_reg <= CCR_RDY_RISING;
					end
				end
				CCR_RDY_RISING: begin
					if (!en_reg) begin
						rdy_state_reg <= CCR_RDY_LOW;
					end else if (rdy_cnt_reg == 32'h0) begin
						rdy_state_reg <= CCR_RDY_HIGH;
					end
				end
				CCR_RDY_HIGH: begin
					if (!en_reg) begin
						rdy_state_reg <= CCR_RDY_FALLING;
					end
				end
				default: begin
					if (en_reg) begin
						rdy_state_reg <= CCR_RDY_HIGH;
					end else if (rdy_cnt_reg == 32'h0) begin
						rdy_state_reg <= CCR_RDY_LOW;
					end
				end
			endcase
		end
	end

	// Ready is high in steady high and while falling
	// Holding it through the fall means the drop marks the end of shutdown
	assign controller_ready = (rdy_state_reg == CCR_RDY_HIGH) || (rdy_state_reg == CCR_RDY_FALLING);

	// Sink for the delay-versus-timeout compare and reg_wdata; nothing reads it
	wire unused_ok = (64'(READY_DELAY) < TIMEOUT_CYCLES) | (|reg_wdata);
endmodule
`default_nettype wire

//--- design/ccr_consts.svh
// Purpose: Constants for the controller capability word.
// Assumes: 64-bit word at register offset 0x0.
// Notes:   Implementation values are parameters of the top module.
`ifndef CCR_CONSTS_SVH
`define CCR_CONSTS_SVH

`define CCR_CAP_OFFSET      12'h000
`define CCR_DBL_BASE        16'h1000
`define CCR_PAGE_EXP_BASE   5'd12
`define CCR_STRIDE_EXP_BASE 5'd2
`define CCR_MAX_EXP_HI      55
`define CCR_MAX_EXP_LO      52
`define CCR_MIN_EXP_HI      51
`define CCR_MIN_EXP_LO      48
`define CCR_BOOT_BIT        45
`define CCR_CSS_HI          44
`define CCR_CSS_LO          37
`define CCR_SUBRST_BIT      36
`define CCR_DOORBELL_STRIDE_HI        35
`define CCR_DOORBELL_STRIDE_LO        32
`define CCR_TO_HI           31
`define CCR_TO_LO           24
`define CCR_TO_UNIT_MS      500
`define CCR_CLK_MHZ         250
`define CCR_NVM_CSS_MASK    8'h01

`endif

//--- design/ccr_dbl_decode.sv
// Purpose: Maps a register address onto a doorbell slot.
// Assumes: Word-aligned addresses; stride from the capability word.
// Notes:   Pure combinational decode.
`include "ccr_consts.svh"
`default_nettype none
module ccr_dbl_decode
	import ccr_pkg::*;
#(
	parameter int unsigned NUM_QUEUES = 16
) (
	// Lookup port
	ccr_dbl_if.dec dbl
);
	logic [15:0] rel;
	logic [15:0] slot;
	logic [15:0] low_mask;

	// Slot index is offset over stride; low bits must be zero
	always_comb begin
		rel      = dbl.addr - `CCR_DBL_BASE;
		slot     = rel >> (`CCR_STRIDE_EXP_BASE + {1'b0, dbl.stride});
		low_mask = 16'((17'h1 << (`CCR_STRIDE_EXP_BASE + {1'b0, dbl.stride})) - 17'h1);
		dbl.hit  = (dbl.addr >= `CCR_DBL_BASE) && ((rel & low_mask) == 16'h0)
			&& (slot < 16'(2 * NUM_QUEUES));
		dbl.is_completion = slot[0];  // Odd slots are completion heads
		dbl.queue_id      = slot[12:1];
	end
endmodule
`default_nettype wire

//--- design/ccr_dbl_if.sv
// Purpose: Carries doorbell lookup between top and decoder.
// Assumes: Single clock.
// Notes:   Combinational request and answer.
`default_nettype none
interface ccr_dbl_if;
	logic [15:0] addr;
	logic [3:0]  stride;
	logic        hit;
	logic        is_completion;
	logic [11:0] queue_id;
	modport top (output addr, output stride, input hit, input is_completion, input queue_id);
	modport dec (input addr, input stride, output hit, output is_completion, output queue_id);
endinterface
`default_nettype wire

//--- design/ccr_pkg.sv
// Purpose: Types shared by the capability register modules.
// Assumes: Constants come from ccr_consts.svh.
// Notes:   Types only.
`default_nettype none
package ccr_pkg;
	typedef enum logic [1:0] {
		CCR_RDY_LOW,
		CCR_RDY_RISING,
		CCR_RDY_HIGH,
		CCR_RDY_FALLING
	} ccr_rdy_state_t;
	typedef logic [63:0] ccr_word_t;
endpackage
`default_nettype wire

//--- test/ccr_cap_monitor.sv
// Purpose: Port assertions for the capability register.
// Assumes: Bound into ccr_cap_regs; one clock.
// Notes:   Ready bound follows READY_DELAY.
`default_nettype none
module ccr_cap_monitor #(
	parameter int unsigned READY_DELAY = 16
) (
	// Watched ports
	input wire logic        clk,
	input wire logic        rst,
	input wire logic        reg_rd,
	input wire logic        reg_wr,
	input wire logic [15:0] reg_addr,
	input wire logic [31:0] reg_rdata_reg,
	input wire logic        reg_rvalid_reg,
	input wire logic        dbl_hit_reg,
	input wire logic        dbl_completion_reg,
	input wire logic [11:0] dbl_queue_reg,
	input wire logic        controller_enable,
	input wire logic        controller_ready,
	input wire logic [63:0] controller_capabilities
);
	timeunit 1ns;
	timeprecision 1ps;
	localparam int RMAX = READY_DELAY + 3;
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	a_rd_answer: assert property (reg_rd |=> reg_rvalid_reg) else $error("read unanswered");
	a_rd_pulse: assert property (!reg_rd |=> !reg_rvalid_reg) else $error("stray rvalid");
	a_hi_read: assert property (reg_rd && reg_addr == 16'h4 |=> reg_rdata_reg == controller_capabilities[63:32])
		else $error("high word wrong");
	a_lo_read: assert property (reg_rd && reg_addr == 16'h0 |=> reg_rdata_reg == controller_capabilities[31:0])
		else $error("low word wrong");
	a_resv_zero: assert property (controller_capabilities[63:56] == 8'h0 && controller_capabilities[47:46] == 2'h0
		&& controller_capabilities[23:19] == 5'h0) else $error("reserved bits set");
	a_css_nonzero: assert property (|controller_capabilities[44:37]) else $error("no command set");
	a_wr_ignored: assert property (reg_wr |=> $stable(controller_capabilities)) else $error("cap changed");
	a_dbl_first: assert property (reg_wr && reg_addr == 16'h1000 |=> dbl_hit_reg && !dbl_completion_reg
		&& dbl_queue_reg == 12'h0) else $error("queue 0 tail missed");
	a_dbl_low: assert property (!reg_wr || reg_addr < 16'h1000 |=> !dbl_hit_reg) else $error("stray hit");
	a_rdy_rise: assert property (controller_enable && !controller_ready |-> ##[1:RMAX]
		(controller_ready || !controller_enable)) else $error("ready late rising");
	a_rdy_fall: assert property (!controller_enable && controller_ready |-> ##[1:RMAX]
		(!controller_ready || controller_enable)) else $error("ready late falling");
	c_hi_read: cover property (reg_rd && reg_addr == 16'h4);
	c_dbl_hit: cover property (dbl_hit_reg && dbl_completion_reg);
	c_rdy_up: cover property ($rose(controller_ready));
endmodule
bind ccr_cap_regs ccr_cap_monitor #(.READY_DELAY(READY_DELAY)) u_mon (.clk, .rst, .reg_rd, .reg_wr,
	.reg_addr, .reg_rdata_reg, .reg_rvalid_reg, .dbl_hit_reg, .dbl_completion_reg, .dbl_queue_reg,
	.controller_enable, .controller_ready, .controller_capabilities);
`default_nettype wire

//--- test/tb_top.sv
// Purpose: Self-checking bench for the capability register.
// Assumes: Inputs driven at falling edge.
// Notes:   Short ready delay keeps the run brief.
`default_nettype none
module tb_top;
	import ccr_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int RD = 2;
	localparam logic [3:0] MAXE = 4'h5, MINE = 4'h1, STRD = 4'h1;
	localparam logic       BOOT = 1'h1, SUBR = 1'h1;
	localparam logic [7:0] COMMAND_SETS_MASK = 8'h01, TOUT = 8'h02;
	localparam int         NQ = 4;
	// Expected word built field by field; no page size is ever programmed
	localparam logic [63:0] CAP = {8'h0, MAXE, MINE, 2'h0, BOOT, COMMAND_SETS_MASK, SUBR, STRD, TOUT, 24'h0};
	typedef struct packed {logic rd; logic [15:0] a; logic [31:0] d; logic [13:0] q;} ccr_row_t;
	logic        clk = 0, rst = 1, reg_rd = 0, reg_wr = 0, controller_enable = 0;
	logic [15:0] reg_addr = 16'h0;
	logic [31:0] reg_wdata = 32'h0, reg_rdata_reg;
	logic        reg_rvalid_reg, dbl_hit_reg, dbl_completion_reg, controller_ready;
	logic [11:0] dbl_queue_reg;
	ccr_word_t   controller_capabilities;
	int          n_mismatch = 0, n_tests = 0, i, w;
	// Reads, then doorbell writes at stride 8 bytes, misses last
	ccr_row_t rows [9] = '{'{1'h1, 16'h0, CAP[31:0], 14'h0}, '{1'h1, 16'h4, CAP[63:32], 14'h0},
		'{1'h1, 16'h8, 32'h0, 14'h0}, '{1'h0, 16'h1000, 32'h0, 14'h2000}, '{1'h0, 16'h1008, 32'h0, 14'h3000},
		'{1'h0, 16'h1038, 32'h0, 14'h3003}, '{1'h0, 16'h1040, 32'h0, 14'h0}, '{1'h0, 16'h1004, 32'h0, 14'h0},
		'{1'h0, 16'h0, 32'h0, 14'h0}};
	ccr_cap_regs #(.PAGE_MAX_EXP(MAXE), .PAGE_MIN_EXP(MINE), .BOOT_SUPPORT(BOOT), .SUBRST_SUPPORT(SUBR),
		.DBL_STRIDE(STRD), .READY_TIMEOUT(TOUT), .READY_DELAY(RD), .NUM_QUEUES(NQ))
		dut (.clk, .rst, .reg_rd, .reg_wr, .reg_addr, .reg_wdata, .reg_rdata_reg, .reg_rvalid_reg, .dbl_hit_reg,
		.dbl_completion_reg, .dbl_queue_reg, .controller_enable, .controller_ready, .controller_capabilities);
	task automatic op(input ccr_row_t r);
		@(negedge clk);
		reg_rd = r.rd;
		reg_wr = !r.rd;
		reg_addr = r.a;
		reg_wdata = 32'hffffffff; // All ones, so a leaking write shows
		@(negedge clk);
		reg_rd = 1'h0;
		reg_wr = 1'h0;
	endtask
	task automatic chk(input string s, input logic [63:0] e, input logic [63:0] g);
		n_tests++;
		if (g !== e) begin
			n_mismatch++;
			$display("ERROR %s expected %h seen %h", s, e, g);
		end
	endtask
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	initial forever #2 clk = ~clk;
	// Watchdog well past the expected run of under a hundred cycles
	initial begin
		#20000;
		n_mismatch++;
		print_verdict();
	end
	initial begin
		repeat (8) @(posedge clk);
		@(negedge clk);
		rst = 1'h0;
		chk("reset", 64'h0, {reg_rdata_reg, reg_rvalid_reg, dbl_hit_reg, controller_ready});
		$display("reset test done");
		for (i = 0; i < 9; i++) begin
			op(rows[i]);
			chk("rvalid", rows[i].rd, reg_rvalid_reg);
			if (rows[i].rd)
				chk("rdata", rows[i].d, reg_rdata_reg);
			else if (rows[i].q[13])
				chk("doorbell", rows[i].q, {dbl_hit_reg, dbl_completion_reg, dbl_queue_reg});
			else
				chk("doorbell miss", 0, dbl_hit_reg);
		end
		chk("cap", CAP, controller_capabilities);
		$display("row tests done");
		// Enable up then down, ready within the bound
		for (w = 0; w < 2; w++) begin
			@(negedge clk);
			controller_enable = (w == 0);
			i = 0;
			while (controller_ready !== (w == 0) && i < 40) begin
				@(negedge clk);
				i++;
			end
			chk("ready wait", 1, i <= RD + 3);
			$display("ready edge test done");
		end
		// Mid-run reset with ready high; ready must drop, then come back
		controller_enable = 1'h1;
		repeat (8) @(negedge clk);
		chk("ready up", 1, controller_ready);
		rst = 1'h1;
		repeat (2) @(negedge clk);
		rst = 1'h0;
		chk("reset mid", 0, {reg_rvalid_reg, dbl_hit_reg, controller_ready});
		repeat (6) @(negedge clk);
		chk("ready again", 1, controller_ready);
		$display("mid reset test done");
		print_verdict();
	end
endmodule
`default_nettype wire
